// ---- shared/lmrtc_pkg.sv ----
// constants shared by both ends of the line mode link
`default_nettype none
package lmrtc_pkg;
	// ---------------------------------------------
	// operating mode codes
	// ---------------------------------------------
	localparam logic [2:0] MODE_STBY = 3'h0;
	localparam logic [2:0] MODE_FWD = 3'h1;
	localparam logic [2:0] MODE_UNBAL = 3'h2;
	localparam logic [2:0] MODE_REV = 3'h3;
	localparam logic [2:0] MODE_RING = 3'h4;
	localparam logic [2:0] MODE_LOOP = 3'h5;
	localparam logic [2:0] MODE_TIPOPEN = 3'h6;
	localparam logic [2:0] MODE_DENY = 3'h7;
	// ---------------------------------------------
	// controller register map
	// ---------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CAD = 4'h8;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DSEL_BIT = 3;
	localparam int CTRL_BATTERY_SELECT_BIT = 4;
	localparam int CTRL_CAD_BIT = 5;
	localparam int CTRL_TEST_BIT = 6;
	localparam int CTRL_ECD_BIT = 7;
	localparam int CTRL_APD_BIT = 8;
	localparam int STAT_DET_BIT = 0;
	localparam int STAT_ALM_BIT = 1;
	localparam int STAT_TRIP_BIT = 2;
	localparam int STAT_TDONE_BIT = 3;
	localparam int STAT_PD_BIT = 4;
	localparam int STAT_BUSY_BIT = 5;
	localparam int STAT_MODE_LSB = 8;
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [23:0] CAD_RST = 24'h00_03e8;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int TONE_TIME_US = 100;
	localparam int TONE_CYC = TONE_TIME_US * CLK_MHZ;
	localparam int ALM_PERSIST_US = 300;
	localparam int ALM_CYC = ALM_PERSIST_US * CLK_MHZ;
	localparam int CAD_SILENT_MULT = 2;
	// ---------------------------------------------
	// controller sequencer states
	// ---------------------------------------------
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_RING = 5'b00010,
		H_SIL = 5'b00100,
		H_T1 = 5'b01000,
		H_T2 = 5'b10000
	} lmrtc_host_e;
endpackage : lmrtc_pkg
`default_nettype wire

// ---- shared/lmrtc_if.sv ----
// mode and detector lines between controller and line interface
`default_nettype none
interface lmrtc_if #(parameter int RW = 8);
	logic [2:0] mode;
	logic detector_select;
	logic battery_select;
	logic [RW-1:0] ring_signal_input;
	logic loop_detect_n;
	logic thermal_alarm_n;
	modport dev (input mode, input detector_select, input battery_select,
		input ring_signal_input, output loop_detect_n, output thermal_alarm_n);
	modport host (output mode, output detector_select, output battery_select,
		output ring_signal_input, input loop_detect_n, input thermal_alarm_n);
endinterface : lmrtc_if
`default_nettype wire

// ---- rtl/lmrtc_mode_dec.sv ----
// one-hot decode of a 3-bit operating mode
`default_nettype none
module lmrtc_mode_dec #(
	parameter bit UNBAL_EN = 1'b1
) (
	input wire logic [2:0] mode,
	output logic is_fwd,
	output logic is_ring_bal,
	output logic is_ring_unbal,
	output logic is_loop,
	output logic is_tipopen,
	output logic is_deny
);
	// ---------------------------------------------
	// decode
	// ---------------------------------------------
	assign is_fwd = (mode == lmrtc_pkg::MODE_FWD);
	assign is_ring_bal = (mode == lmrtc_pkg::MODE_RING);
	// unbalanced code only on variants that have it
	assign is_ring_unbal = UNBAL_EN && (mode == lmrtc_pkg::MODE_UNBAL);
	assign is_loop = (mode == lmrtc_pkg::MODE_LOOP);
	assign is_tipopen = (mode == lmrtc_pkg::MODE_TIPOPEN);
	assign is_deny = (mode == lmrtc_pkg::MODE_DENY);
endmodule : lmrtc_mode_dec
`default_nettype wire

// ---- rtl/lmrtc_dev.sv ----
// line interface end: mode decode, ring gating, ring-trip latch, thermal
// Summary of operation
// - mode 100 selects balanced ringing
// - controller picks high battery for ringing; code forces it for mode 100 only, mode 010 follows battery select
// - ring input passes only while ringing
// - ring trip latches loop detect low
// - only an external mode change releases latch
// - ring trip cuts the ring input
// - ring trip forces forward feed internally
// - silent cadence part may use any mode but 100, which becomes forward feed
// - ring to silence ratio one to two
// - mode 010 unbalanced ringing, same trip detect
// - mode 101 loopback, low battery chosen
// - loopback drives loop detect low
// - loopback drives thermal alarm low
// - two-step tone test without echo disable
// - one-step tone test with echo disabled
// - mode 110 tip open, ring path only
// - detector select picks hook or ground key
// - mode 111 shuts down, battery ignored
// - over temperature: alarm low, detect high, shutdown
// - cooled: release alarm, repeat while hot
// - power denial ends thermal cycling
// - mode 001 forward feed, also after trip
// - battery select high or low, independent
`default_nettype none
module lmrtc_dev #(
	parameter int RW = 8,
	parameter bit UNBAL_EN = 1'b1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	lmrtc_if.dev lnk,
	input wire logic ring_trip_sense,
	input wire logic hook_sense,
	input wire logic gkey_sense,
	input wire logic over_temp,
	output logic tip_en,
	output logic ring_en,
	output logic loop_term,
	output logic unbal_tip_gnd,
	output logic batt_high,
	output logic shut_down,
	output logic [2:0] eff_mode,
	output logic [RW-1:0] ring_drive
);
	// ---------------------------------------------
	// parameter check
	// ---------------------------------------------
	if (RW < 1) begin : g_bad_rw
		$error("lmrtc_dev: RW must be at least 1");
	end

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	logic [2:0] mode_prev_q;
	logic trip_q;
	logic trip_d;
	logic det_n_q;
	logic det_n_d;
	logic alm_n_q;
	logic alm_n_d;
	logic tip_en_q;
	logic tip_en_d;
	logic ring_en_q;
	logic ring_en_d;
	logic loop_term_q;
	logic loop_term_d;
	logic unbal_q;
	logic unbal_d;
	logic batt_high_q;
	logic batt_high_d;
	logic shut_down_q;
	logic shut_down_d;
	logic [2:0] eff_mode_q;
	logic [2:0] eff_mode_d;
	logic [RW-1:0] ring_drive_q;
	logic [RW-1:0] ring_drive_d;

	// ---------------------------------------------
	// combinational terms
	// ---------------------------------------------
	logic ext_chg;
	logic ext_deny;
	logic thermal_sd;
	logic [2:0] base_mode;
	logic base_ring_bal;
	logic base_ring_unbal;
	logic base_ringing;
	logic trip_set;
	logic eff_ring_bal;
	logic eff_ring_unbal;
	logic eff_ringing;
	logic eff_loop;
	logic eff_tipopen;
	logic eff_deny;
	logic supervise;

	// external mode change: any differing new value
	assign ext_chg = (lnk.mode != mode_prev_q);

	// power denial from the external lines
	assign ext_deny = (lnk.mode == lmrtc_pkg::MODE_DENY);

	// thermal shutdown only while not already in power denial
	assign thermal_sd = over_temp && !ext_deny;

	// mode before this cycle's trip: deny, forced feed, or external
	assign base_mode = (ext_deny || thermal_sd) ? lmrtc_pkg::MODE_DENY :
		(trip_q && !ext_chg) ? lmrtc_pkg::MODE_FWD : lnk.mode;

	// ---------------------------------------------
	// decode of the pre-trip mode
	// ---------------------------------------------
	lmrtc_mode_dec #(
		.UNBAL_EN(UNBAL_EN)
	) u_dec_base (
		.mode(base_mode),
		.is_fwd(),
		.is_ring_bal(base_ring_bal),
		.is_ring_unbal(base_ring_unbal),
		.is_loop(),
		.is_tipopen(),
		.is_deny()
	);

	// both ringing flavours share one peak-current trip comparison
	assign base_ringing = base_ring_bal || base_ring_unbal;

	// trip seen only while actually ringing
	assign trip_set = base_ringing && ring_trip_sense;

	// a trip moves to forward feed in the same cycle
	assign eff_mode_d = trip_set ? lmrtc_pkg::MODE_FWD : base_mode;

	// ---------------------------------------------
	// decode of the effective mode
	// ---------------------------------------------
	lmrtc_mode_dec #(
		.UNBAL_EN(UNBAL_EN)
	) u_dec_eff (
		.mode(eff_mode_d),
		.is_fwd(),
		.is_ring_bal(eff_ring_bal),
		.is_ring_unbal(eff_ring_unbal),
		.is_loop(eff_loop),
		.is_tipopen(eff_tipopen),
		.is_deny(eff_deny)
	);

	assign eff_ringing = eff_ring_bal || eff_ring_unbal;

	// ---------------------------------------------
	// ring-trip latch
	// ---------------------------------------------
	// set wins over a clear arriving in the same cycle
	assign trip_d = trip_set || (trip_q && !ext_chg);

	// ---------------------------------------------
	// line path control
	// ---------------------------------------------
	// ring input reaches the line only in ringing
	assign ring_drive_d = eff_ringing ? lnk.ring_signal_input : '0;

	// tip path off in tip open and when shut down
	assign tip_en_d = !(eff_deny || eff_tipopen);

	// ring path off only when shut down
	assign ring_en_d = !eff_deny;

	// internal termination across the amplifiers
	assign loop_term_d = eff_loop;

	// tip held at ground during unbalanced bursts
	assign unbal_d = eff_ring_unbal;

	// battery follows select, frozen while in power denial
	assign batt_high_d = ext_deny ? batt_high_q : lnk.battery_select;

	// shut down by power denial or over temperature
	assign shut_down_d = ext_deny || thermal_sd;

	// ---------------------------------------------
	// detector outputs
	// ---------------------------------------------
	// supervision source chosen by detector select
	assign supervise = lnk.detector_select ? hook_sense : gkey_sense;

	// loop detect priority: heat, trip, loopback, deny, ringing, supervision
	assign det_n_d = thermal_sd ? 1'b1 :
		trip_d ? 1'b0 :
		eff_loop ? 1'b0 :
		eff_deny ? 1'b1 :
		eff_ringing ? 1'b1 :
		!supervise;

	// alarm follows die heat; loopback exercises it too
	assign alm_n_d = !(over_temp || eff_loop);

	// ---------------------------------------------
	// state and output flops
	// ---------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_prev_q <= lmrtc_pkg::MODE_STBY;
			trip_q <= 1'b0;
			eff_mode_q <= lmrtc_pkg::MODE_STBY;
			shut_down_q <= 1'b0;
			batt_high_q <= 1'b0;
		end else begin
			mode_prev_q <= lnk.mode;
			trip_q <= trip_d;
			eff_mode_q <= eff_mode_d;
			shut_down_q <= shut_down_d;
			batt_high_q <= batt_high_d;
		end
	end

	// line path drive
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tip_en_q <= 1'b0;
			ring_en_q <= 1'b0;
			loop_term_q <= 1'b0;
			unbal_q <= 1'b0;
			ring_drive_q <= '0;
		end else begin
			tip_en_q <= tip_en_d;
			ring_en_q <= ring_en_d;
			loop_term_q <= loop_term_d;
			unbal_q <= unbal_d;
			ring_drive_q <= ring_drive_d;
		end
	end

	// detector lines, idle high
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			det_n_q <= 1'b1;
			alm_n_q <= 1'b1;
		end else begin
			det_n_q <= det_n_d;
			alm_n_q <= alm_n_d;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign lnk.loop_detect_n = det_n_q;
	assign lnk.thermal_alarm_n = alm_n_q;
	assign tip_en = tip_en_q;
	assign ring_en = ring_en_q;
	assign loop_term = loop_term_q;
	assign unbal_tip_gnd = unbal_q;
	assign batt_high = batt_high_q;
	assign shut_down = shut_down_q;
	assign eff_mode = eff_mode_q;
	assign ring_drive = ring_drive_q;
endmodule : lmrtc_dev
`default_nettype wire

// ---- rtl/lmrtc_host.sv ----
// controller end: wishbone registers, ring cadence, loopback test, alarm
`default_nettype none
module lmrtc_host #(
	parameter int RW = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	lmrtc_if.host lnk,
	input wire logic [RW-1:0] ring_wave,
	output logic tone_en,
	output logic echo_off
);
	if (RW < 1) begin : g_bad_rw
		$error("lmrtc_host: RW must be at least 1");
	end
	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	lmrtc_pkg::lmrtc_host_e st_q, st_d;
	logic ack_q;
	logic [31:0] dat_q, dat_d;
	logic [8:0] ctrl_q, ctrl_d;
	logic [23:0] cad_q, cad_d;
	logic [24:0] cnt_q, cnt_d;
	logic [11:0] alm_cnt_q, alm_cnt_d;
	logic trip_q, tdone_q, pd_q, tone_q, echo_q, dsel_q, battery_select_q, battery_select_d;
	logic [2:0] mode_q, mode_d;
	logic [RW-1:0] ring_q;
	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	logic req, wr, wr_ctrl, wr_cad, start, trip_ev, alm_hit, ring_last, sil_last, tone_last;
	logic [31:0] wmask, ctrl_w, cad_w, stat_v;
	logic [2:0] sil_mode;
	assign req = wb_cyc_i && wb_stb_i;
	assign wr = req && wb_we_i && ack_q;
	assign wr_ctrl = wr && (wb_adr_i == lmrtc_pkg::REG_CTRL);
	assign wr_cad = wr && (wb_adr_i == lmrtc_pkg::REG_CAD);
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign ctrl_w = ({23'h00_0000, ctrl_q} & ~wmask) | (wb_dat_i & wmask);
	assign cad_w = ({8'h00, cad_q} & ~wmask) | (wb_dat_i & wmask);
	assign start = wr_ctrl && ctrl_w[lmrtc_pkg::CTRL_TEST_BIT] && (st_q == lmrtc_pkg::H_IDLE);
	assign stat_v = {21'h00_0000, mode_q, 2'b00, (st_q != lmrtc_pkg::H_IDLE), pd_q, tdone_q,
		trip_q, !lnk.thermal_alarm_n, !lnk.loop_detect_n};
	// read mux, unmapped reads zero
	assign dat_d = (wb_adr_i == lmrtc_pkg::REG_CTRL) ? {23'h00_0000, ctrl_q} :
		(wb_adr_i == lmrtc_pkg::REG_STAT) ? stat_v :
		(wb_adr_i == lmrtc_pkg::REG_CAD) ? {8'h00, cad_q} : 32'h0000_0000;
	// ---------------------------------------------
	// sequencer terms
	// ---------------------------------------------
	// ignore the detector for two cycles after entering a burst
	assign trip_ev = (st_q == lmrtc_pkg::H_RING) && (cnt_q >= 25'h000_0002) && !lnk.loop_detect_n;
	assign ring_last = (cnt_q == {1'b0, cad_q} - 25'h000_0001);
	// silence lasts twice the burst
	assign sil_last = (cnt_q == 25'(lmrtc_pkg::CAD_SILENT_MULT) * {1'b0, cad_q} - 25'h000_0001);
	assign tone_last = (cnt_q == 25'(lmrtc_pkg::TONE_CYC - 1));
	assign alm_hit = (alm_cnt_q == 12'(lmrtc_pkg::ALM_CYC - 1));
	// silent part: programmed mode, forward feed if that is balanced ringing (100)
	assign sil_mode = (ctrl_q[2:0] == lmrtc_pkg::MODE_RING) ? lmrtc_pkg::MODE_FWD : ctrl_q[2:0];
	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 25'h000_0001;
		mode_d = pd_q ? lmrtc_pkg::MODE_DENY : ctrl_q[2:0];
		battery_select_d = ctrl_q[lmrtc_pkg::CTRL_BATTERY_SELECT_BIT];
		ctrl_d = wr_ctrl ? {ctrl_w[8:7], 1'b0, ctrl_w[5:0]} : ctrl_q;
		case (st_q)
			lmrtc_pkg::H_IDLE: begin
				cnt_d = '0;
				if (start) begin
					st_d = ctrl_w[lmrtc_pkg::CTRL_ECD_BIT] ? lmrtc_pkg::H_T2 : lmrtc_pkg::H_T1;
				end else if (ctrl_q[lmrtc_pkg::CTRL_CAD_BIT] && !pd_q) begin
					st_d = lmrtc_pkg::H_RING;
				end
			end
			lmrtc_pkg::H_RING: begin
				mode_d = lmrtc_pkg::MODE_RING;
				if (trip_ev) begin
					st_d = lmrtc_pkg::H_IDLE;
					ctrl_d[lmrtc_pkg::CTRL_CAD_BIT] = 1'b0;
				end else if (!ctrl_q[lmrtc_pkg::CTRL_CAD_BIT] || pd_q) begin
					st_d = lmrtc_pkg::H_IDLE;
				end else if (ring_last) begin
					st_d = lmrtc_pkg::H_SIL;
					cnt_d = '0;
				end
			end
			lmrtc_pkg::H_SIL: begin
				mode_d = sil_mode;
				if (!ctrl_q[lmrtc_pkg::CTRL_CAD_BIT] || pd_q) begin
					st_d = lmrtc_pkg::H_IDLE;
				end else if (sil_last) begin
					st_d = lmrtc_pkg::H_RING;
					cnt_d = '0;
				end
			end
			lmrtc_pkg::H_T1: begin
				mode_d = lmrtc_pkg::MODE_FWD;
				if (tone_last) begin
					st_d = lmrtc_pkg::H_T2;
					cnt_d = '0;
				end
			end
			lmrtc_pkg::H_T2: begin
				mode_d = lmrtc_pkg::MODE_LOOP;
				if (tone_last) begin
					st_d = lmrtc_pkg::H_IDLE;
				end
			end
			default: st_d = lmrtc_pkg::H_IDLE;
		endcase
		// battery forced by the ringing and loopback modes
		if (mode_d == lmrtc_pkg::MODE_RING) begin
			battery_select_d = 1'b1;
		end else if (mode_d == lmrtc_pkg::MODE_LOOP) begin
			battery_select_d = 1'b0;
		end
	end
	// persistent alarm counter, loopback alarm excluded
	assign alm_cnt_d = (lnk.thermal_alarm_n || mode_q == lmrtc_pkg::MODE_LOOP) ? 12'h000 :
		alm_hit ? alm_cnt_q : alm_cnt_q + 12'h001;
	assign cad_d = wr_cad ? cad_w[23:0] : cad_q;
	// ---------------------------------------------
	// flops
	// ---------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= lmrtc_pkg::H_IDLE;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			ctrl_q <= lmrtc_pkg::CTRL_RST;
			cad_q <= lmrtc_pkg::CAD_RST;
			cnt_q <= '0;
			alm_cnt_q <= 12'h000;
		end else begin
			st_q <= st_d;
			ack_q <= req && !ack_q;
			dat_q <= dat_d;
			ctrl_q <= ctrl_d;
			cad_q <= cad_d;
			cnt_q <= cnt_d;
			alm_cnt_q <= alm_cnt_d;
		end
	end
	// link drive and sticky status, set wins over clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_q <= lmrtc_pkg::MODE_STBY;
			dsel_q <= 1'b0;
			battery_select_q <= 1'b0;
			ring_q <= '0;
			tone_q <= 1'b0;
			echo_q <= 1'b0;
			trip_q <= 1'b0;
			tdone_q <= 1'b0;
			pd_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			dsel_q <= ctrl_q[lmrtc_pkg::CTRL_DSEL_BIT];
			battery_select_q <= battery_select_d;
			ring_q <= ring_wave;
			tone_q <= (st_d == lmrtc_pkg::H_T1) || (st_d == lmrtc_pkg::H_T2);
			// echo off only for a one-step test started from idle by this write
			echo_q <= (st_d == lmrtc_pkg::H_T2) && ((st_q == lmrtc_pkg::H_T2) ? echo_q :
				((st_q == lmrtc_pkg::H_IDLE) && ctrl_w[lmrtc_pkg::CTRL_ECD_BIT]));
			trip_q <= trip_ev || (trip_q && !wr_ctrl);
			tdone_q <= (st_q == lmrtc_pkg::H_T2 && tone_last) || (tdone_q && !wr_ctrl);
			pd_q <= (alm_hit && ctrl_q[lmrtc_pkg::CTRL_APD_BIT]) || (pd_q && !wr_ctrl);
		end
	end
	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign lnk.mode = mode_q;
	assign lnk.detector_select = dsel_q;
	assign lnk.battery_select = battery_select_q;
	assign lnk.ring_signal_input = ring_q;
	assign tone_en = tone_q;
	assign echo_off = echo_q;
endmodule : lmrtc_host
`default_nettype wire

// ---- dv/lmrtc_sva.sv ----
// assertions on the line mode link and the line end outputs
`default_nettype none
module lmrtc_sva #(
	parameter int RW = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] mode,
	input wire logic battery_select,
	input wire logic [RW-1:0] ring_signal_input,
	input wire logic loop_detect_n,
	input wire logic thermal_alarm_n,
	input wire logic ring_trip_sense,
	input wire logic over_temp,
	input wire logic batt_high,
	input wire logic shut_down,
	input wire logic [2:0] eff_mode,
	input wire logic [RW-1:0] ring_drive
);
	// ---
	// helpers and clocking
	// ---
	wire logic is_rng = (mode == lmrtc_pkg::MODE_RING) || (mode == lmrtc_pkg::MODE_UNBAL);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ---
	// ring trip, gating, loopback, thermal, battery
	// ---
	a_trip_latch: assert property (
		is_rng && ring_trip_sense && !over_temp |=> !loop_detect_n && eff_mode == lmrtc_pkg::MODE_FWD)
		else $error("ring trip not latched");
	a_latch_holds: assert property (
		is_rng && $stable(mode) && eff_mode == lmrtc_pkg::MODE_FWD && !over_temp |=> !loop_detect_n && ring_drive == '0)
		else $error("trip latch lost");
	a_ring_pass: assert property (
		is_rng && $stable(mode) && eff_mode == mode && !ring_trip_sense && !over_temp
		|=> ring_drive == $past(ring_signal_input))
		else $error("ring sample not passed");
	a_ring_block: assert property (
		!is_rng |=> ring_drive == '0)
		else $error("ring sample leaked");
	a_loop_flags: assert property (
		mode == lmrtc_pkg::MODE_LOOP && !over_temp |=> !loop_detect_n && !thermal_alarm_n)
		else $error("loopback flags wrong");
	a_thermal_trip: assert property (
		over_temp |=> !thermal_alarm_n && loop_detect_n && shut_down)
		else $error("thermal shutdown missing");
	a_cool_release: assert property (
		!over_temp && mode != lmrtc_pkg::MODE_LOOP |=> thermal_alarm_n)
		else $error("alarm not released");
	a_deny_freeze: assert property (
		mode == lmrtc_pkg::MODE_DENY && $stable(mode) && !over_temp |=> shut_down && $stable(batt_high))
		else $error("power denial not held");
	a_batt_follow: assert property (
		mode != lmrtc_pkg::MODE_DENY |=> batt_high == $past(battery_select))
		else $error("battery select ignored");
endmodule : lmrtc_sva
`default_nettype wire

// ---- dv/line_mode_ring_trip_control_tb.sv ----
// bench joining controller end and line end over the link
`default_nettype none
module line_mode_ring_trip_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ---
	// stimulus and observed signals
	// ---
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [7:0] wave = 8'h00;
	logic trip = 1'b0, hook = 1'b0, gkey = 1'b0, hot = 1'b0;
	logic [31:0] rdat;
	logic ack, tone_en, echo_off, tip_en, ring_en, loop_term, batt_high, shut_down, unbal;
	logic [2:0] eff_mode;
	logic [7:0] ring_drive;
	int n_fail = 0;
	int check_count = 0;
	int cyc_n = 0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	// ---
	// both ends, link and checker
	// ---
	lmrtc_if #(.RW(8)) lnk ();
	lmrtc_host #(.RW(8)) u_lmrtc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.lnk(lnk.host), .ring_wave(wave), .tone_en(tone_en), .echo_off(echo_off));
	lmrtc_dev #(.RW(8)) u_lmrtc_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(lnk.dev), .ring_trip_sense(trip),
		.hook_sense(hook), .gkey_sense(gkey), .over_temp(hot), .tip_en(tip_en), .ring_en(ring_en),
		.loop_term(loop_term), .unbal_tip_gnd(unbal), .batt_high(batt_high), .shut_down(shut_down),
		.eff_mode(eff_mode), .ring_drive(ring_drive));
	lmrtc_sva #(.RW(8)) u_lmrtc_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode(lnk.mode),
		.battery_select(lnk.battery_select), .ring_signal_input(lnk.ring_signal_input),
		.loop_detect_n(lnk.loop_detect_n), .thermal_alarm_n(lnk.thermal_alarm_n), .ring_trip_sense(trip),
		.over_temp(hot), .batt_high(batt_high), .shut_down(shut_down), .eff_mode(eff_mode),
		.ring_drive(ring_drive));
	// ---
	// tasks
	// ---
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			n_fail++;
			$display("FAIL t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (ack === 1'b1) break;
		end
		if (k == 50) n_fail++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		wb(1'b0, a, 32'h0000_0000);
	endtask : rd
	// clock, watchdog and read-data monitor
	initial forever #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 10000) begin
			n_fail++;
			test_done();
		end
	end
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && !we && exp_q.size() > 0) check(rdat & msk_q.pop_front(), exp_q.pop_front());
	end
	// ---
	// main sequence
	// ---
	initial begin
		int k, nr, ns;
		logic [2:0] m;
		logic bs, ds, pb, dn;
		void'($urandom(43062));
		tick(3);
		sys_rst <= 1'b0;
		rd(lmrtc_pkg::REG_CTRL, 32'(lmrtc_pkg::CTRL_RST), 32'hffff_ffff);
		rd(lmrtc_pkg::REG_CAD, 32'(lmrtc_pkg::CAD_RST), 32'hffff_ffff);
		wb(1'b1, 4'hc, 32'hffff_ffff);
		rd(4'hc, 32'h0000_0000, 32'hffff_ffff);
		$display("test registers done");
		pb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			bs = 1'($urandom);
			ds = 1'($urandom);
			hook <= 1'($urandom);
			gkey <= 1'($urandom);
			wave <= 8'($urandom) | 8'h01;
			wb(1'b1, lmrtc_pkg::REG_CTRL, {27'h0, bs, ds, m});
			tick(4);
			if (m != lmrtc_pkg::MODE_DENY) pb = bs;
			if (m == lmrtc_pkg::MODE_RING) pb = 1'b1;
			if (m == lmrtc_pkg::MODE_LOOP) pb = 1'b0;
			dn = !(ds ? hook : gkey);
			if (m == lmrtc_pkg::MODE_LOOP) dn = 1'b0;
			if (m inside {lmrtc_pkg::MODE_RING, lmrtc_pkg::MODE_UNBAL, lmrtc_pkg::MODE_DENY}) dn = 1'b1;
			check({lnk.mode, batt_high}, {m, pb});
			check({eff_mode, lnk.loop_detect_n}, {m, dn});
			check(lnk.thermal_alarm_n, m != lmrtc_pkg::MODE_LOOP);
			check(ring_drive, (m == lmrtc_pkg::MODE_RING || m == lmrtc_pkg::MODE_UNBAL) ? wave : 8'h00);
			if (m == lmrtc_pkg::MODE_TIPOPEN) check({tip_en, ring_en}, 2'b01);
			if (m == lmrtc_pkg::MODE_LOOP) check(loop_term, 1'b1);
			check(unbal, m == lmrtc_pkg::MODE_UNBAL);
			if (m == lmrtc_pkg::MODE_DENY) check(shut_down, 1'b1);
		end
		$display("test mode table done");
		for (int i = 0; i < 2; i++) begin
			m = i ? lmrtc_pkg::MODE_UNBAL : lmrtc_pkg::MODE_RING;
			wb(1'b1, lmrtc_pkg::REG_CTRL, {27'h0, 2'b11, m});
			hook <= 1'b0;
			tick(3);
			trip <= 1'b1;
			tick(1);
			trip <= 1'b0;
			tick(20);
			check({lnk.mode, lnk.loop_detect_n}, {m, 1'b0});
			check({eff_mode, ring_drive}, {lmrtc_pkg::MODE_FWD, 8'h00});
			wb(1'b1, lmrtc_pkg::REG_CTRL, {27'h0, 2'b11, lmrtc_pkg::MODE_FWD});
			tick(3);
			check(lnk.loop_detect_n, 1'b1);
		end
		$display("test ring trip done");
		for (int i = 0; i < 2; i++) begin
			hot <= 1'b1;
			tick(3);
			check({lnk.thermal_alarm_n, lnk.loop_detect_n, shut_down}, 3'b011);
			hot <= 1'b0;
			tick(3);
			check({lnk.thermal_alarm_n, lnk.loop_detect_n, shut_down}, 3'b110);
		end
		wb(1'b1, lmrtc_pkg::REG_CTRL, {27'h0, 2'b11, lmrtc_pkg::MODE_DENY});
		hot <= 1'b1;
		tick(3);
		hot <= 1'b0;
		tick(3);
		check({lnk.thermal_alarm_n, shut_down}, 2'b11);
		$display("test thermal done");
		wb(1'b1, lmrtc_pkg::REG_CAD, 32'h0000_0008);
		wb(1'b1, lmrtc_pkg::REG_CTRL, 32'h0000_0029);
		for (k = 0; lnk.mode !== lmrtc_pkg::MODE_RING && k < 100; k++) tick(1);
		check(lnk.battery_select, 1'b1);
		for (nr = 0; lnk.mode === lmrtc_pkg::MODE_RING && nr < 100; nr++) tick(1);
		for (ns = 0; lnk.mode !== lmrtc_pkg::MODE_RING && ns < 100; ns++) tick(1);
		check({nr[7:0], ns[7:0]}, {8'h08, 8'h10});
		tick(2);
		trip <= 1'b1;
		tick(1);
		trip <= 1'b0;
		tick(10);
		rd(lmrtc_pkg::REG_STAT, 32'h0000_0004, 32'h0000_0004);
		rd(lmrtc_pkg::REG_CTRL, 32'h0000_0000, 32'h0000_0020);
		$display("test cadence done");
		wb(1'b1, lmrtc_pkg::REG_CTRL, 32'h0000_0040);
		tick(3);
		check({tone_en, lnk.mode}, {1'b1, lmrtc_pkg::MODE_FWD});
		tick(lmrtc_pkg::TONE_CYC);
		check({tone_en, lnk.mode, lnk.battery_select, echo_off}, {1'b1, lmrtc_pkg::MODE_LOOP, 2'b00});
		check({lnk.loop_detect_n, lnk.thermal_alarm_n}, 2'b00);
		tick(lmrtc_pkg::TONE_CYC + 10);
		rd(lmrtc_pkg::REG_STAT, 32'h0000_0008, 32'h0000_0008);
		wb(1'b1, lmrtc_pkg::REG_CTRL, 32'h0000_00c0);
		tick(3);
		check({tone_en, lnk.mode, lnk.battery_select, echo_off}, {1'b1, lmrtc_pkg::MODE_LOOP, 2'b01});
		tick(lmrtc_pkg::TONE_CYC + 10);
		rd(lmrtc_pkg::REG_STAT, 32'h0000_0008, 32'h0000_0008);
		$display("test loopback done");
		wb(1'b1, lmrtc_pkg::REG_CTRL, 32'h0000_0101);
		hot <= 1'b1;
		tick(lmrtc_pkg::ALM_CYC + 10);
		hot <= 1'b0;
		tick(3);
		check({lnk.mode, shut_down, lnk.thermal_alarm_n}, {lmrtc_pkg::MODE_DENY, 2'b11});
		rd(lmrtc_pkg::REG_STAT, 32'h0000_0010, 32'h0000_0010);
		wb(1'b1, lmrtc_pkg::REG_CTRL, 32'h0000_0001);
		tick(3);
		check({lnk.mode, shut_down}, {lmrtc_pkg::MODE_FWD, 1'b0});
		$display("test power deny done");
		tick(2);
		test_done();
	end
endmodule : line_mode_ring_trip_control_tb
`default_nettype wire
